// ===== design/upsc_switch_ctrl.v
// data-line switch and port power switch control with thermal loop
// assumes analog comparators and pins arrive asynchronously; all pass two flops
`include "upsc_map.vh"
module upsc_switch_ctrl (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [1:0] powerState,
  input  wire [2:0] profile,
  input  wire       profileAccepted,
  input  wire       emulationCycling,
  input  wire       emulationTimeout,
  input  wire       dedicatedCharging,
  input  wire       data_switch_in_dedicated_charging,
  input  wire       detectDataSwitchEnable,
  input  wire       coreSupplyOk,
  input  wire       busDischarging,
  input  wire       port_power_enable,
  input  wire       attachEvent,
  input  wire [3:0] strap_select_pin,
  input  wire       progLimitWrite,
  input  wire [2:0] progLimit,
  input  wire       overLimit,
  input  wire       overShort,
  input  wire       overTemp,
  input  wire       belowHyst,
  input  wire       controlChanged,
  output reg        data_line_switch,
  output reg        portPowerSwitch,
  output reg        bypassCapActive,
  output reg  [2:0] current_limit_setting,
  output reg        constant_current_limiting,
  output reg        low_current_threshold,
  output reg        softStartActive,
  output reg        shortLimitActive,
  output reg        errorRequest,
  output reg        alertN,
  output reg        profileRemove,
  output reg        commMode,
  output reg  [2:0] strapLimit
);
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam NSYNC = 10;
  wire [NSYNC-1:0] rawIn = {strap_select_pin, port_power_enable, coreSupplyOk,
                            overLimit, overShort, overTemp, belowHyst};
  reg  [NSYNC-1:0] syncA;
  reg  [NSYNC-1:0] syncB;
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= rawIn[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate
  wire [3:0] strapS   = syncB[9:6];
  wire       enS      = syncB[5];
  wire       vddOk    = syncB[4];
  wire       ovLimS   = syncB[3];
  wire       ovShortS = syncB[2];
  wire       hotS     = syncB[1];
  wire       coolS    = syncB[0];

  // ------------------------------------------------------------
  // strap capture and limit programming
  // ------------------------------------------------------------
  // strap taken after sync pipe fills, once only
  reg [1:0] strapWait;
  reg       strapTaken;
  reg [2:0] progStored;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strapWait  <= 2'h0;
      strapTaken <= 1'b0;
      commMode   <= 1'b0;
      strapLimit <= 3'h7;
      // minimum until the strap is known, so the output never tops the strap
      progStored <= 3'h0;
    end else begin
      if (!strapTaken) begin
        if (strapWait == 2'h3) begin
          strapTaken <= 1'b1;
          commMode   <= strapS[`UPSC_STRAP_COMM];
          strapLimit <= strapS[`UPSC_STRAP_LIM_HI:0];
          progStored <= strapS[`UPSC_STRAP_LIM_HI:0];
        end else begin
          strapWait <= strapWait + 2'h1;
        end
      end else if (progLimitWrite) begin
        progStored <= (progLimit > strapLimit) ? strapLimit : progLimit;
      end
    end
  end

  // ------------------------------------------------------------
  // soft start and short circuit timers
  // ------------------------------------------------------------
  reg enPrev;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) enPrev <= 1'b0;
    else     enPrev <= enS;
  end
  wire softKick = (enS && !enPrev) ||
                  (attachEvent && powerState == `UPSC_PS_DETECT && enS);
  localparam [31:0] SOFT_CYC  = `UPSC_RISE_CYC;
  localparam [31:0] SHORT_CYC = `UPSC_SHORT_LIM_CYC;
  wire softBusy;
  upsc_timer #(.WIDTH(24)) uSoft (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (softKick),
    .abort   (!enS),
    .load    (SOFT_CYC[23:0]),
    .busy    (softBusy),
    .done    ()
  );

  reg  shortPrev;
  wire shortDone;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) shortPrev <= 1'b0;
    else     shortPrev <= ovShortS;
  end
  upsc_timer #(.WIDTH(24)) uShort (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (ovShortS && !shortPrev),
    .abort   (!ovShortS),
    .load    (SHORT_CYC[23:0]),
    .busy    (),
    .done    (shortDone)
  );

  // ------------------------------------------------------------
  // thermal management loop
  // ------------------------------------------------------------
  localparam TH_IDLE    = 3'h0;
  localparam TH_OPEN    = 3'h1;
  localparam TH_CHECK   = 3'h2;
  localparam TH_HOLD    = 3'h3;
  localparam TH_RESTORE = 3'h4;
  reg  [2:0] thState;
  reg  [2:0] thLimit;
  reg        thActive;
  reg        thForcedTrip;
  reg        thSwitchOpen;
  reg        profileBlocked;
  wire       thTimerDone;
  reg        thTimerStart;
  reg [31:0] thLoad;

  // base mode before thermal override
  wire ccBase = (profile == `UPSC_PROF_CDP) ||
                (profile == `UPSC_PROF_DCP && profileAccepted && ovLimS &&
                 progStored < `UPSC_LIM_168) ||
                (emulationCycling && !profileAccepted && emulationTimeout);
  // otherwise trip is the default mode

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thState        <= TH_IDLE;
      thLimit        <= 3'h7;
      thActive       <= 1'b0;
      thForcedTrip   <= 1'b0;
      thSwitchOpen   <= 1'b0;
      profileBlocked <= 1'b0;
      thTimerStart   <= 1'b0;
      thLoad         <= 32'h0;
    end else begin
      thTimerStart <= 1'b0;
      if (controlChanged)
        profileBlocked <= 1'b0;
      case (thState)
        TH_IDLE: begin
          if (hotS && portPowerSwitch) begin
            thActive     <= 1'b1;
            thSwitchOpen <= 1'b1;
            thLimit      <= (progStored == `UPSC_LIM_MIN) ? `UPSC_LIM_MIN : progStored - 3'h1;
            thTimerStart <= 1'b1;
            thLoad       <= `UPSC_RETRY_CYC;
            if (emulationCycling && profileAccepted)
              profileBlocked <= 1'b1;
            thState <= TH_OPEN;
          end
        end
        TH_OPEN: begin
          if (thTimerDone) begin
            thSwitchOpen <= 1'b0;
            thState      <= TH_CHECK;
          end
        end
        TH_CHECK: begin
          if (coolS) begin
            if (thForcedTrip) begin
              thTimerStart <= 1'b1;
              thLoad       <= `UPSC_RESTORE_CYC;
              thState      <= TH_RESTORE;
            end else begin
              thActive <= 1'b0;
              thState  <= TH_IDLE;
            end
          end else if (hotS) begin
            if (thLimit != `UPSC_LIM_MIN) begin
              thSwitchOpen <= 1'b1;
              thLimit      <= thLimit - 3'h1;
              thTimerStart <= 1'b1;
              thLoad       <= `UPSC_RETRY_CYC;
              thState      <= TH_OPEN;
            end else if (ccBase && !thForcedTrip) begin
              thForcedTrip <= 1'b1;
              thLimit      <= (progStored == `UPSC_LIM_MIN) ? `UPSC_LIM_MIN : progStored - 3'h1;
            end else begin
              thState <= TH_HOLD;
            end
          end
        end
        TH_HOLD: begin
          if (coolS) begin
            if (thForcedTrip) begin
              thTimerStart <= 1'b1;
              thLoad       <= `UPSC_RESTORE_CYC;
              thState      <= TH_RESTORE;
            end else begin
              thActive <= 1'b0;
              thState  <= TH_IDLE;
            end
          end
        end
        TH_RESTORE: begin
          if (thTimerDone) begin
            thActive     <= 1'b0;
            thForcedTrip <= 1'b0;
            thState      <= TH_IDLE;
          end
        end
        default: thState <= TH_IDLE;
      endcase
    end
  end

  upsc_timer #(.WIDTH(32)) uTherm (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (thTimerStart),
    .abort   (1'b0),
    .load    (thLoad),
    .busy    (),
    .done    (thTimerDone)
  );

  // ------------------------------------------------------------
  // switch decisions
  // ------------------------------------------------------------
  wire emulOpen  = (profile != `UPSC_PROF_NONE) && (profile != `UPSC_PROF_CDP);
  wire dedOpen   = dedicatedCharging && !data_switch_in_dedicated_charging;
  wire stateOk   = (powerState == `UPSC_PS_ACTIVE) ||
                   (powerState == `UPSC_PS_DETECT && detectDataSwitchEnable);
  wire next_data = vddOk && stateOk && !emulOpen && !dedOpen;
  // thermal opening never requests discharge; the load drains the bus
  wire tripNow   = !constant_current_limiting && ovLimS && portPowerSwitch;
  // trip held until Active is left; without it the switch chatters back on
  reg  tripHold;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      tripHold <= 1'b0;
    else if (tripNow || shortDone)
      tripHold <= 1'b1;
    else if (powerState != `UPSC_PS_ACTIVE)
      tripHold <= 1'b0;
  end
  wire next_pwr  = (powerState == `UPSC_PS_ACTIVE) && enS && !busDischarging && !tripHold &&
                   !thSwitchOpen && !tripNow && !shortDone;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_line_switch          <= 1'b0;
      portPowerSwitch           <= 1'b0;
      bypassCapActive           <= 1'b0;
      current_limit_setting     <= 3'h0;
      constant_current_limiting <= 1'b0;
      low_current_threshold     <= `UPSC_LOWCUR_NORM;
      softStartActive           <= 1'b0;
      shortLimitActive          <= 1'b0;
      errorRequest              <= 1'b0;
      alertN                    <= 1'b1;
      profileRemove             <= 1'b0;
    end else begin
      data_line_switch          <= next_data;
      portPowerSwitch           <= next_pwr;
      bypassCapActive           <= (powerState == `UPSC_PS_DETECT);
      current_limit_setting     <= thActive ? thLimit : progStored;
      constant_current_limiting <= ccBase && !thForcedTrip;
      low_current_threshold     <= thForcedTrip ? `UPSC_LOWCUR_120MA : `UPSC_LOWCUR_NORM;
      softStartActive           <= softBusy;
      shortLimitActive          <= ovShortS;
      errorRequest              <= tripNow || shortDone || tripHold;
      if (tripNow || shortDone)
        alertN <= 1'b0;
      else if (powerState != `UPSC_PS_ERROR && !errorRequest)
        alertN <= 1'b1;
      profileRemove             <= profileBlocked;
    end
  end
endmodule // upsc_switch_ctrl

// ===== design/upsc_timer.v
// down-counting one-shot timer used for soft start, short limit and thermal timers
// assumes start is a one-cycle pulse on sys_clk; restart while busy reloads
module upsc_timer #(
  parameter WIDTH = 24
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire             start,
  input  wire             abort,
  input  wire [WIDTH-1:0] load,
  output reg              busy,
  output reg              done
);
  reg [WIDTH-1:0] count;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy <= 1'b0;
      end else if (start) begin
        count <= load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // upsc_timer

// ===== dv/tb.sv
// self-checking bench for upsc_switch_ctrl with a load model on the port
// assumes a 25 MHz sys_clk; inputs change on the falling edge
`include "upsc_map.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       sys_clk, rst, profileAccepted, emulationCycling, emulationTimeout, dedicatedCharging;
  logic       data_switch_in_dedicated_charging, detectDataSwitchEnable, coreSupplyOk, busDischarging;
  logic       port_power_enable, attachEvent, progLimitWrite, overLimit, overShort, overTemp, belowHyst;
  logic       controlChanged, data_line_switch, portPowerSwitch, bypassCapActive, constant_current_limiting;
  logic       low_current_threshold, softStartActive, shortLimitActive, errorRequest, alertN;
  logic       profileRemove, commMode, shortLoad;
  logic [1:0] powerState;
  logic [2:0] profile, progLimit, current_limit_setting, strapLimit, drawCode;
  logic [3:0] strap_select_pin;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;

  upsc_switch_ctrl u_upsc_switch_ctrl (.*);
  upsc_load_model u_upsc_load_model (.*);

  // ----------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------
  initial sys_clk = 1'b0;
  always #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic goState(input logic [1:0] s, input logic [2:0] p);
    powerState = s;
    profile = p;
    settle(4);
  endtask

  task automatic progWrite(input logic [2:0] v);
    progLimit = v;
    progLimitWrite = 1'b1;
    settle(1);
    progLimitWrite = 1'b0;
    settle(3);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rst, profileAccepted, emulationCycling, emulationTimeout, dedicatedCharging} = 5'h10;
    {data_switch_in_dedicated_charging, detectDataSwitchEnable, busDischarging, port_power_enable} = 4'h0;
    {attachEvent, progLimitWrite, overTemp, belowHyst, controlChanged, shortLoad} = 6'h00;
    coreSupplyOk = 1'b1;
    powerState = `UPSC_PS_SLEEP;
    profile = `UPSC_PROF_NONE;
    progLimit = 3'h0;
    drawCode = 3'h0;
    strap_select_pin = 4'hB;
    settle(3);
    rst = 1'b0;
    settle(12);
    chk("strapLimit", 4'h3, 4'(strapLimit));
    chk("commMode", 4'h1, 4'(commMode));
    strap_select_pin = 4'h7;
    settle(6);
    chk("strapLimit held", 4'h3, 4'(strapLimit));
    chk("switch sleep", 4'h0, 4'(data_line_switch));
    goState(`UPSC_PS_DETECT, `UPSC_PROF_NONE);
    chk("switch detect", 4'h0, 4'(data_line_switch));
    chk("bypass cap", 4'h1, 4'(bypassCapActive));
    detectDataSwitchEnable = 1'b1;
    attachEvent = 1'b1;
    settle(1);
    attachEvent = 1'b0;
    settle(3);
    chk("switch detect enabled", 4'h1, 4'(data_line_switch));
    detectDataSwitchEnable = 1'b0;
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_NONE);
    chk("switch active", 4'h1, 4'(data_line_switch));
    chk("cc plain", 4'h0, 4'(constant_current_limiting));
    chk("low current normal", 4'h0, 4'(low_current_threshold));
    progWrite(3'h7);
    chk("limit clamped", 4'h3, 4'(current_limit_setting));
    progWrite(3'h2);
    chk("limit written", 4'h2, 4'(current_limit_setting));
    progWrite(3'h3);
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_CDP);
    chk("switch cdp", 4'h1, 4'(data_line_switch));
    chk("cc cdp", 4'h1, 4'(constant_current_limiting));
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_DCP);
    chk("switch dcp", 4'h0, 4'(data_line_switch));
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_OTHER);
    chk("switch other", 4'h0, 4'(data_line_switch));
    // profile still being applied, not yet accepted, with the timeout running
    {emulationCycling, emulationTimeout, profileAccepted} = 3'h6;
    settle(4);
    chk("cc cycling", 4'h1, 4'(constant_current_limiting));
    {emulationCycling, emulationTimeout, profileAccepted} = 3'h0;
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_NONE);
    dedicatedCharging = 1'b1;
    settle(4);
    chk("switch dedicated", 4'h0, 4'(data_line_switch));
    data_switch_in_dedicated_charging = 1'b1;
    settle(4);
    chk("switch dedicated kept", 4'h1, 4'(data_line_switch));
    {dedicatedCharging, data_switch_in_dedicated_charging} = 2'h0;
    coreSupplyOk = 1'b0;
    settle(4);
    chk("switch low supply", 4'h0, 4'(data_line_switch));
    coreSupplyOk = 1'b1;
    port_power_enable = 1'b1;
    settle(5);
    chk("soft start", 4'h1, 4'(softStartActive));
    chk("power on", 4'h1, 4'(portPowerSwitch));
    busDischarging = 1'b1;
    settle(2);
    chk("power discharging", 4'h0, 4'(portPowerSwitch));
    busDischarging = 1'b0;
    settle(2600);
    chk("soft start over", 4'h0, 4'(softStartActive));
    chk("power back", 4'h1, 4'(portPowerSwitch));
    drawCode = 3'h5;
    settle(4);
    chk("trip power", 4'h0, 4'(portPowerSwitch));
    chk("trip error", 4'h1, 4'(errorRequest));
    chk("trip alert", 4'h0, 4'(alertN));
    drawCode = 3'h0;
    goState(`UPSC_PS_ERROR, `UPSC_PROF_NONE);
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_NONE);
    settle(8);
    chk("alert released", 4'h1, 4'(alertN));
    chk("power restored", 4'h1, 4'(portPowerSwitch));
    shortLoad = 1'b1;
    settle(4);
    chk("short limiting", 4'h1, 4'(shortLimitActive));
    chk("short power held", 4'h1, 4'(portPowerSwitch));
    // short response timer runs about 50 cycles before the error
    settle(60);
    chk("short power", 4'h0, 4'(portPowerSwitch));
    chk("short error", 4'h1, 4'(errorRequest));
    shortLoad = 1'b0;
    goState(`UPSC_PS_ERROR, `UPSC_PROF_NONE);
    goState(`UPSC_PS_ACTIVE, `UPSC_PROF_NONE);
    chk("power after short", 4'h1, 4'(portPowerSwitch));
    {emulationCycling, profileAccepted} = 2'h3;
    overTemp = 1'b1;
    settle(5);
    chk("hot power", 4'h0, 4'(portPowerSwitch));
    chk("hot limit", 4'h2, 4'(current_limit_setting));
    chk("profile removed", 4'h1, 4'(profileRemove));
    overTemp = 1'b0;
    belowHyst = 1'b1;
    controlChanged = 1'b1;
    settle(1);
    controlChanged = 1'b0;
    settle(4);
    chk("profile released", 4'h0, 4'(profileRemove));
    give_verdict();
  end
endmodule // tb

// ===== dv/upsc_load_model.sv
// portable device load seen through the port power switch
// assumes draw codes use the scale of the limit codes
module upsc_load_model (
  input  wire logic       portPowerSwitch,
  input  wire logic [2:0] current_limit_setting,
  input  wire logic [2:0] drawCode,
  input  wire logic       shortLoad,
  output logic            overLimit,
  output logic            overShort
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // comparators
  // ----------------------------------------
  // no current with the switch open, so both comparators rest low
  assign overLimit = portPowerSwitch && (drawCode > current_limit_setting);
  assign overShort = portPowerSwitch && shortLoad;
endmodule // upsc_load_model

// ===== dv/upsc_switch_ctrl_sva.sv
// assertions on the ports of upsc_switch_ctrl
// assumes 1 cycle latency for local inputs and 3 for synced pins
`include "upsc_map.vh"
module upsc_switch_ctrl_sva (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [1:0] powerState,
  input wire logic [2:0] profile,
  input wire logic       dedicatedCharging,
  input wire logic       data_switch_in_dedicated_charging,
  input wire logic       coreSupplyOk,
  input wire logic       busDischarging,
  input wire logic       port_power_enable,
  input wire logic       overLimit,
  input wire logic       overTemp,
  input wire logic       data_line_switch,
  input wire logic       portPowerSwitch,
  input wire logic       bypassCapActive,
  input wire logic [2:0] current_limit_setting,
  input wire logic       constant_current_limiting,
  input wire logic       softStartActive,
  input wire logic       errorRequest,
  input wire logic       alertN,
  input wire logic [2:0] strapLimit
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire inActive = powerState == `UPSC_PS_ACTIVE;
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence sTripCause;
    portPowerSwitch && !constant_current_limiting && overLimit;
  endsequence
  sequence sTripDone;
    !portPowerSwitch && errorRequest && !alertN;
  endsequence
  // four cycles high so the synchroniser has passed the edge
  sequence sEnableRise;
    inActive && !port_power_enable ##1 (inActive && port_power_enable) [*4];
  endsequence
  AST_ACTIVE_CLOSED: assert property (
    (inActive && profile == `UPSC_PROF_NONE && !dedicatedCharging && coreSupplyOk) [*4] |=> data_line_switch)
    else $error("data switch open in plain active state");
  AST_PROFILE_OPEN: assert property (
    inActive && profile == `UPSC_PROF_OTHER |=> !data_line_switch) else $error("data switch closed during profile");
  AST_DEDICATED_OPEN: assert property (
    dedicatedCharging && !data_switch_in_dedicated_charging |=> !data_line_switch)
    else $error("data switch closed in dedicated charging");
  AST_SLEEP_OPEN: assert property (
    powerState == `UPSC_PS_SLEEP |=> !data_line_switch) else $error("data switch closed in sleep");
  AST_SUPPLY_OPEN: assert property (
    !coreSupplyOk [*4] |=> !data_line_switch) else $error("data switch closed with low core supply");
  AST_DISCHARGE_OFF: assert property (
    busDischarging |=> !portPowerSwitch) else $error("power switch on while bus discharges");
  AST_LIMIT_CLAMP: assert property (
    current_limit_setting <= strapLimit) else $error("limit above strapped limit");
  AST_DETECT_CAP: assert property (
    powerState == `UPSC_PS_DETECT [*2] |=> bypassCapActive) else $error("bypass cap not applied in detect");
  AST_TRIP: assert property (
    sTripCause |-> ##[1:4] sTripDone) else $error("trip did not open switch and alert");
  AST_TRIP_HELD: assert property (
    inActive && errorRequest |=> !portPowerSwitch) else $error("power switch back on before error handling");
  AST_SOFT_START: assert property (
    sEnableRise |=> softStartActive) else $error("no soft start on enable");
  AST_CDP_CC: assert property (
    (inActive && profile == `UPSC_PROF_CDP && !overTemp) [*2] |=> constant_current_limiting)
    else $error("no constant current in cdp");
endmodule // upsc_switch_ctrl_sva

bind upsc_switch_ctrl upsc_switch_ctrl_sva u_upsc_switch_ctrl_sva (.*);

// ===== shared/upsc_map.vh
// constants for the usb port switch control block
// assumes a 25 MHz sys_clk and a 3-bit current limit code
`ifndef UPSC_MAP_VH
`define UPSC_MAP_VH
// power states
`define UPSC_PS_SLEEP   2'h0
`define UPSC_PS_DETECT  2'h1
`define UPSC_PS_ACTIVE  2'h2
`define UPSC_PS_ERROR   2'h3
// emulation profiles
`define UPSC_PROF_NONE  3'h0
`define UPSC_PROF_CDP   3'h1
`define UPSC_PROF_DCP   3'h2
`define UPSC_PROF_OTHER 3'h3
// limit codes
`define UPSC_LIM_MIN    3'h0
`define UPSC_LIM_168    3'h4
// strap field positions: bit 3 comm mode, bits 2:0 limit
`define UPSC_STRAP_COMM 3
`define UPSC_STRAP_LIM_HI 2
// timing (clock 25 MHz)
`define UPSC_CLK_MHZ        25
`define UPSC_SHORT_LIM_US   2
`define UPSC_SHORT_LIM_CYC  (`UPSC_SHORT_LIM_US * `UPSC_CLK_MHZ)
`define UPSC_RISE_US        100
`define UPSC_RISE_CYC       (`UPSC_RISE_US * `UPSC_CLK_MHZ)
`define UPSC_RETRY_MS       200
`define UPSC_RETRY_CYC      (`UPSC_RETRY_MS * 1000 * `UPSC_CLK_MHZ)
`define UPSC_RESTORE_MS     200
`define UPSC_RESTORE_CYC    (`UPSC_RESTORE_MS * 1000 * `UPSC_CLK_MHZ)
// low current threshold codes
`define UPSC_LOWCUR_NORM    1'b0
`define UPSC_LOWCUR_120MA   1'b1
`endif
